// File: hdl/medr_metering_energy_data_regs.sv
// Operation
// (RQ1) Accumulators 42 bits; reads return top 32
// (RQ2) Write loads top bits, low ten cleared
// (RQ3) Accumulate at 12800Hz on fast clocks
// (RQ4) Accumulate at 2979Hz on slow clock
// (RQ5) One output pulse per two overflows
// (RQ6) Pulse counters count every overflow
// (RQ7) Separate positive/negative accumulators and counters per path
// (RQ8) Line frequency read-only 16 bits, resets zero
// (RQ9) Frequency refreshed every 320ms
// (RQ10) Frequency at 0.05Hz per lsb, 35-75Hz
// (RQ11) Raw wave signed, refreshed every 0.3ms
// (RQ12) Instant DC signed, refreshed every 20ms
// (RQ13) Averaged DC signed, refreshed every 1.28s
// (RQ14) Resets restore calibration defaults
// (RQ15) Path one power gain, signed, default zero
// (RQ16) Current-one RMS gain register, signed
// (RQ17) Resets restore all result registers
// (RQ18) Software should not write result registers
// (RQ19) Intervals stretch by K and 60Hz factor
// (RQ20) Single 32-bit access, others untouched
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module medr_metering_energy_data_regs
#(
    parameter longint RAW_UPD_CYC  = medr_pkg::RAW_UPD_US
                                     * medr_pkg::US_CYC,
    parameter longint DC_UPD_CYC   = medr_pkg::DC_UPD_US
                                     * medr_pkg::US_CYC,
    parameter longint AVG_UPD_CYC  = medr_pkg::AVG_UPD_US
                                     * medr_pkg::US_CYC,
    parameter longint FREQ_UPD_CYC = medr_pkg::FREQ_UPD_US
                                     * medr_pkg::US_CYC,
    parameter longint FAST_CYC     = medr_pkg::FAST_CYC,
    parameter longint SLOW_CYC     = medr_pkg::SLOW_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        grid_60hz,
    input  wire logic [31:0] path1_power,
    input  wire logic [31:0] path2_power,
    input  wire logic [31:0] chan_m_raw_in,
    input  wire logic [31:0] chan_m_dc_in,
    input  wire logic [31:0] chan_m_dc_avg_in,
    input  wire logic [31:0] apparent_power_in,
    input  wire logic [15:0] line_freq_in,
    output logic      [31:0] path1_gain_out,
    output logic      [31:0] cur1_gain_out,
    output logic      [1:0]  energy_pulse_output
);

    localparam int NACC = 4;

    logic                     setup_hit;
    logic [15:0]              widx;
    logic [NACC-1:0][41:0]    acc_q;
    logic [NACC-1:0][31:0]    pcnt_q;
    logic [NACC-1:0]          ovf_par_q;
    logic [NACC-1:0][15:0]    acc_idx;
    logic [NACC-1:0][15:0]    cnt_idx;
    logic [NACC-1:0][42:0]    acc_sum;
    logic [NACC-1:0][41:0]    acc_add;
    logic [31:0]              raw_q;
    logic [31:0]              dci_q;
    logic [31:0]              dca_q;
    logic [31:0]              ap2_q;
    logic [31:0]              gain_p_q;
    logic [31:0]              gain_i1_q;
    logic [15:0]              freq_q;
    logic [31:0]              ctrl_q;
    logic [31:0]              tick_cnt_q;
    logic                     tick;
    logic [63:0]              scale;
    logic [3:0]               divk;
    logic                     wr_en;

    medr_pkg::medr_apb_state_t st_q;

    assign widx  = paddr[17:2];
    assign wr_en = psel && penable && pwrite
                   && st_q == medr_pkg::MEDR_APB_ACCESS;
    assign divk  = ctrl_q[medr_pkg::CTRL_DIVK_LO +: medr_pkg::CTRL_DIVK_W];
    assign acc_idx = {medr_pkg::IDX_PATH2_NEG_ENERGY_ACC,
                      medr_pkg::IDX_PATH2_POS_ENERGY_ACC,
                      medr_pkg::IDX_PATH1_NEG_ENERGY_ACC,
                      medr_pkg::IDX_PATH1_POS_ENERGY_ACC};
    assign cnt_idx = {medr_pkg::IDX_PATH2_NEG_PULSE_CNT,
                      medr_pkg::IDX_PATH2_POS_PULSE_CNT,
                      medr_pkg::IDX_PATH1_NEG_PULSE_CNT,
                      medr_pkg::IDX_PATH1_POS_PULSE_CNT};
    assign setup_hit = psel && !penable;

    // APB: one wait-free access phase; pready registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q    <= medr_pkg::MEDR_APB_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (setup_hit)
        begin
            st_q    <= medr_pkg::MEDR_APB_ACCESS;
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
        else
        begin
            st_q    <= medr_pkg::MEDR_APB_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Read data prepared in setup, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= medr_pkg::RST_WORD;
        end
        else if (setup_hit && !pwrite)
        begin
            prdata <= medr_pkg::RST_WORD;
            case (widx)
                medr_pkg::IDX_CHAN_M_RAW_WAVE:      prdata <= raw_q; // [RQ11]
                medr_pkg::IDX_CHAN_M_DC_INST:       prdata <= dci_q; // [RQ12]
                medr_pkg::IDX_CHAN_M_DC_AVG:        prdata <= dca_q; // [RQ13]
                medr_pkg::IDX_APPARENT_POWER_CUR2:  prdata <= ap2_q;
                medr_pkg::IDX_PATH1_POWER_GAIN_CAL: prdata <= gain_p_q;
                medr_pkg::IDX_CUR1_RMS_GAIN_CAL:    prdata <= gain_i1_q;
                medr_pkg::IDX_LINE_FREQ_RESULT:
                    prdata <= {16'h0000, freq_q}; // [RQ8]
                medr_pkg::IDX_METER_CTRL:           prdata <= ctrl_q;
                default:
                begin
                    for (int i = 0; i < NACC; i++)
                    begin
                        if (widx == acc_idx[i])
                            prdata <= acc_q[i][41:10]; // [RQ1]
                        if (widx == cnt_idx[i])
                            prdata <= pcnt_q[i];
                    end
                end
            endcase
        end
    end

    // Plain word registers; each write touches one register only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_p_q  <= medr_pkg::RST_WORD; // [RQ14] [RQ15]
            gain_i1_q <= medr_pkg::RST_WORD; // [RQ16]
            ctrl_q    <= medr_pkg::RST_CTRL;
        end
        else if (wr_en)
        begin
            if (widx == medr_pkg::IDX_PATH1_POWER_GAIN_CAL)
                gain_p_q <= pwdata; // [RQ20]
            if (widx == medr_pkg::IDX_CUR1_RMS_GAIN_CAL)
                gain_i1_q <= pwdata;
            if (widx == medr_pkg::IDX_METER_CTRL)
                ctrl_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            path1_gain_out <= medr_pkg::RST_WORD;
            cur1_gain_out  <= medr_pkg::RST_WORD;
        end
        else
        begin
            path1_gain_out <= gain_p_q;
            cur1_gain_out  <= gain_i1_q;
        end
    end

    // Accumulation tick; slow mode models the 32768Hz metering clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= 32'h0000_0000;
            tick       <= 1'b0;
        end
        else if (tick_cnt_q == 32'h0000_0000)
        begin
            tick       <= ctrl_q[medr_pkg::CTRL_ACC_EN];
            tick_cnt_q <= ctrl_q[medr_pkg::CTRL_SLOW]
                          ? 32'(SLOW_CYC - 1)   // [RQ4]
                          : 32'(FAST_CYC - 1);  // [RQ3]
        end
        else
        begin
            tick       <= 1'b0;
            tick_cnt_q <= tick_cnt_q - 32'h0000_0001;
        end
    end

    // Accumulators and pulse counters, one per direction and path
    generate
        for (genvar g = 0; g < NACC; g++)
        begin : g_acc
            logic [31:0] pw;
            logic        acc_wr;
            logic        ovf;
            if (g < 2)
            begin : g_p1
                assign pw = path1_power;
            end
            else
            begin : g_p2
                assign pw = path2_power;
            end
            // Even index positive, odd negative: magnitude of matching sign
            assign acc_add[g] = ((g % 2 == 0) ? !pw[31] : pw[31])
                ? {10'h000, ((g % 2 == 0) ? pw : 32'(-pw))}
                : 42'h000_0000_0000;
            assign acc_sum[g] = {1'b0, acc_q[g]} + {1'b0, acc_add[g]};
            assign acc_wr     = wr_en && widx == acc_idx[g];
            assign ovf        = tick && acc_sum[g][42] && !acc_wr;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    acc_q[g]     <= 42'h000_0000_0000; // [RQ17]
                    pcnt_q[g]    <= medr_pkg::RST_WORD;
                    ovf_par_q[g] <= 1'b0;
                end
                else
                begin
                    if (acc_wr)
                        acc_q[g] <= {pwdata, 10'h000}; // [RQ2]
                    else if (tick)
                        acc_q[g] <= acc_sum[g][41:0];
                    // A counter write must not cost the accumulator a tick
                    if (wr_en && widx == cnt_idx[g])
                        pcnt_q[g] <= pwdata; // [RQ7]
                    else if (ovf)
                        pcnt_q[g] <= pcnt_q[g] + 32'h0000_0001; // [RQ6]
                    if (ovf)
                        ovf_par_q[g] <= !ovf_par_q[g]; // [RQ5]
                end
            end
        end
    endgenerate

    // Output pulse toggles on every overflow of either direction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            energy_pulse_output <= 2'b00;
        else if (ctrl_q[medr_pkg::CTRL_PULSE_EN])
            energy_pulse_output <= {ovf_par_q[2] ^ ovf_par_q[3],
                                    ovf_par_q[0] ^ ovf_par_q[1]}; // [RQ5]
        else
            energy_pulse_output <= 2'b00;
    end

    // Scale factor x10: K-fold, and 12/10 on a 60Hz grid
    // Widen before adding one, so K of sixteen does not wrap to zero
    assign scale = (64'(divk) + 64'd1)
                   * (grid_60hz ? 64'd12 : 64'd10); // [RQ19]

    // Result refresh timers
    logic [63:0] t_raw_q, t_dc_q, t_avg_q, t_frq_q;
    logic        ld_raw, ld_dc, ld_avg, ld_frq;
    assign ld_raw = t_raw_q >= (64'(RAW_UPD_CYC) * scale) / 64'd10;
    assign ld_dc  = t_dc_q  >= (64'(DC_UPD_CYC)  * scale) / 64'd10;
    assign ld_avg = t_avg_q >= (64'(AVG_UPD_CYC) * scale) / 64'd10;
    assign ld_frq = t_frq_q >= (64'(FREQ_UPD_CYC) * scale) / 64'd10;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t_raw_q <= 64'h0;
            t_dc_q  <= 64'h0;
            t_avg_q <= 64'h0;
            t_frq_q <= 64'h0;
        end
        else
        begin
            t_raw_q <= ld_raw ? 64'h1 : t_raw_q + 64'h1;
            t_dc_q  <= ld_dc  ? 64'h1 : t_dc_q  + 64'h1;
            t_avg_q <= ld_avg ? 64'h1 : t_avg_q + 64'h1;
            t_frq_q <= ld_frq ? 64'h1 : t_frq_q + 64'h1;
        end
    end

    // Results: refresh wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_q  <= medr_pkg::RST_WORD;
            dci_q  <= medr_pkg::RST_WORD;
            dca_q  <= medr_pkg::RST_WORD;
            ap2_q  <= medr_pkg::RST_WORD;
            freq_q <= medr_pkg::RST_FREQ; // [RQ8]
        end
        else
        begin
            if (ld_raw)
                raw_q <= chan_m_raw_in; // [RQ11]
            else if (wr_en && widx == medr_pkg::IDX_CHAN_M_RAW_WAVE)
                raw_q <= pwdata;
            if (ld_dc)
                dci_q <= chan_m_dc_in; // [RQ12]
            else if (wr_en && widx == medr_pkg::IDX_CHAN_M_DC_INST)
                dci_q <= pwdata;
            if (ld_avg)
            begin
                dca_q <= chan_m_dc_avg_in; // [RQ13]
                ap2_q <= apparent_power_in;
            end
            else if (wr_en)
            begin
                if (widx == medr_pkg::IDX_CHAN_M_DC_AVG)
                    dca_q <= pwdata;
                if (widx == medr_pkg::IDX_APPARENT_POWER_CUR2)
                    ap2_q <= pwdata;
            end
            // 0.05Hz per lsb; 35..75Hz is codes 700..1500
            if (ld_frq)
                freq_q <= (line_freq_in < 16'd700) ? 16'd700
                        : (line_freq_in > 16'd1500) ? 16'd1500
                        : line_freq_in; // [RQ9] [RQ10]
        end
    end

endmodule
`default_nettype wire

// File: hdl/medr_pkg.sv
package medr_pkg;

    // Printed offsets are word indices; byte address is four times the index
    localparam logic [15:0] IDX_CHAN_M_RAW_WAVE      = 16'h10ce;
    localparam logic [15:0] IDX_CHAN_M_DC_INST       = 16'h10cf;
    localparam logic [15:0] IDX_CHAN_M_DC_AVG        = 16'h10d0;
    localparam logic [15:0] IDX_APPARENT_POWER_CUR2  = 16'h10dc;
    localparam logic [15:0] IDX_PATH1_POWER_GAIN_CAL = 16'h10e8;
    localparam logic [15:0] IDX_CUR1_RMS_GAIN_CAL    = 16'h10eb;
    localparam logic [15:0] IDX_PATH1_POS_ENERGY_ACC = 16'h10f0;
    localparam logic [15:0] IDX_PATH1_NEG_ENERGY_ACC = 16'h10f1;
    localparam logic [15:0] IDX_PATH1_POS_PULSE_CNT  = 16'h10f2;
    localparam logic [15:0] IDX_PATH1_NEG_PULSE_CNT  = 16'h10f3;
    localparam logic [15:0] IDX_PATH2_POS_ENERGY_ACC = 16'h10f6;
    localparam logic [15:0] IDX_PATH2_NEG_ENERGY_ACC = 16'h10f7;
    localparam logic [15:0] IDX_PATH2_POS_PULSE_CNT  = 16'h10f8;
    localparam logic [15:0] IDX_PATH2_NEG_PULSE_CNT  = 16'h10f9;
    localparam logic [15:0] IDX_LINE_FREQ_RESULT     = 16'h10fd;
    localparam logic [15:0] IDX_METER_CTRL           = 16'h10fe;

    localparam int ACC_W      = 42;
    localparam int ACC_LOW_W  = 10;
    localparam int FREQ_W     = 16;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] RST_FREQ  = 16'h0000;
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;

    // Control register fields
    localparam int CTRL_ACC_EN   = 0;
    localparam int CTRL_PULSE_EN = 1;
    localparam int CTRL_SLOW     = 2;
    localparam int CTRL_DIVK_LO  = 4;
    localparam int CTRL_DIVK_W   = 4;

    // Timing: clock and accumulation rates
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint ACC_FAST_HZ   = 12_800;
    localparam longint ACC_SLOW_HZ   = 2_979;
    localparam longint FAST_CYC      = CLK_HZ / ACC_FAST_HZ;
    localparam longint SLOW_CYC      = CLK_HZ / ACC_SLOW_HZ;
    // Refresh intervals in microseconds, scaled by K and the 60Hz factor
    localparam longint RAW_UPD_US    = 300;
    localparam longint DC_UPD_US     = 20_000;
    localparam longint AVG_UPD_US    = 1_280_000;
    localparam longint FREQ_UPD_US   = 320_000;
    localparam longint US_CYC        = CLK_HZ / 1_000_000;
    localparam int     CNT_W         = 32;

    typedef enum logic [1:0] {
        MEDR_APB_IDLE   = 2'b00,
        MEDR_APB_ACCESS = 2'b01
    } medr_apb_state_t;

endpackage

// File: tb/medr_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module medr_regs_asserts
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] path1_gain_out,
    input wire logic [31:0] cur1_gain_out,
    input wire logic [1:0]  energy_pulse_output
);
    localparam logic [17:0] A_G1 =
        {medr_pkg::IDX_PATH1_POWER_GAIN_CAL, 2'b00};
    localparam logic [17:0] A_G2 =
        {medr_pkg::IDX_CUR1_RMS_GAIN_CAL, 2'b00};
    logic wr_g1;
    logic wr_g2;
    assign wr_g1 = psel && penable && pready && pwrite && paddr == A_G1;
    assign wr_g2 = psel && penable && pready && pwrite && paddr == A_G2;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_next: assert property (
        psel && !penable |=> pready)
        else $error("No ready after setup");
    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("Ready held longer than one cycle");
    a_no_slverr: assert property (
        psel && penable |-> !pslverr)
        else $error("Unexpected slave error");
    // Gain outputs are a second register stage behind the written word
    a_gain1_load: assert property (
        wr_g1 |=> ##1 path1_gain_out == $past(pwdata, 2))
        else $error("Power gain not loaded");
    a_gain2_load: assert property (
        wr_g2 |=> ##1 cur1_gain_out == $past(pwdata, 2))
        else $error("Current gain not loaded");
    a_gain_hold: assert property (
        !wr_g1 && !wr_g2 && !$past(wr_g1) && !$past(wr_g2)
        |=> $stable(path1_gain_out) && $stable(cur1_gain_out))
        else $error("Gain changed without write");
    a_reset_clears: assert property (
        $rose(presetn) |-> path1_gain_out == 32'h0000_0000
        && cur1_gain_out == 32'h0000_0000
        && energy_pulse_output == 2'b00)
        else $error("Outputs not cleared by reset");
    a_pulse_spacing: assert property (
        $changed(energy_pulse_output)
        |=> $stable(energy_pulse_output) [*8])
        else $error("Pulse output toggled too soon");
    a_prdata_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("Read data changed without read");
endmodule

bind medr_metering_energy_data_regs medr_regs_asserts u_medr_regs_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .path1_gain_out(path1_gain_out),
    .cur1_gain_out(cur1_gain_out), .energy_pulse_output(energy_pulse_output)
);
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int FC = 20;
    localparam int SC = 60;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, grid_60hz, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, p1, p2, raw, dc, avg, ap, prdata, g1, g2, rd, v;
    logic [15:0] freq;
    logic [1:0]  pulse;
    logic [31:0] seed = 32'h0000_0062;
    logic [31:0] n [4] = '{default: 32'h0000_0000};
    logic [3:0]  ov [2] = '{default: 4'h0};
    logic [15:0] accs [4] = '{16'h10f0, 16'h10f1, 16'h10f6, 16'h10f7};
    logic [15:0] ri [5] = '{16'h10ce, 16'h10cf, 16'h10d0, 16'h10dc, 16'h10fd};
    logic [15:0] rl [16] = '{16'h10ce, 16'h10cf, 16'h10d0, 16'h10dc,
        16'h10e8, 16'h10eb, 16'h10f0, 16'h10f1, 16'h10f2, 16'h10f3,
        16'h10f6, 16'h10f7, 16'h10f8, 16'h10f9, 16'h10fd, 16'h10fb};
    int          wt [5] = '{30, 200, 400, 400, 300};
    int          err_total = 0;
    int          num_checks = 0;
    int          k;

    medr_metering_energy_data_regs #(.RAW_UPD_CYC(30), .DC_UPD_CYC(200),
        .AVG_UPD_CYC(400), .FREQ_UPD_CYC(300), .FAST_CYC(FC),
        .SLOW_CYC(SC)) u_medr_metering_energy_data_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .grid_60hz(grid_60hz),
        .path1_power(p1), .path2_power(p2), .chan_m_raw_in(raw),
        .chan_m_dc_in(dc), .chan_m_dc_avg_in(avg), .apparent_power_in(ap),
        .line_freq_in(freq), .path1_gain_out(g1), .cur1_gain_out(g2),
        .energy_pulse_output(pulse));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Frequency code saturates at the 35 Hz and 75 Hz ends
    function automatic logic [31:0] fexp(input logic [15:0] f);
        return {16'h0000,
                f < 16'h02bc ? 16'h02bc : f > 16'h05dc ? 16'h05dc : f};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] i,
                       input logic [31:0] d);
        int c;
        c = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the edge at which pready is seen high
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (pready !== 1'b1 && c < 50);
        if (c >= 50)
            chk(32'h0000_0000, 32'h0000_0001);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rst_chk();
        foreach (rl[i])
        begin
            apb(1'b0, rl[i], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    initial
    begin
        #200_000;
        chk(32'h0000_0000, 32'h0000_0001);
        tally_and_finish();
    end

    initial
    begin
        {psel, penable, pwrite, grid_60hz, paddr, pwdata} = '0;
        {p1, p2, raw, dc, avg, ap, freq} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        apb(1'b1, 16'h10fd, xs());
        apb(1'b0, 16'h10fd, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 2; i++)
        begin
            v = xs();
            apb(1'b1, i ? 16'h10eb : 16'h10e8, v);
            apb(1'b0, i ? 16'h10eb : 16'h10e8, 32'h0000_0000);
            chk(rd, v);
            chk(i ? g2 : g1, v);
        end
        $display("test reset and gains done");
        apb(1'b1, medr_pkg::IDX_METER_CTRL, 32'h0000_0003);
        for (int a = 0; a < 5; a++)
        begin
            k = a % 4;
            if (a == 4)
                apb(1'b1, medr_pkg::IDX_METER_CTRL, 32'h0000_0007);
            for (int r = 0; r < 2 - a / 4; r++)
            begin
                // Top word all ones: a single 2^30 sample must wrap it
                apb(1'b1, accs[k], 32'hffff_ffff);
                v = k[0] ? 32'hc000_0000 : 32'h4000_0000;
                if (k[1])
                    p2 <= v;
                else
                    p1 <= v;
                repeat (a == 4 ? SC : FC) @(posedge pclk);
                p1 <= 32'h0000_0000;
                p2 <= 32'h0000_0000;
                apb(1'b0, accs[k], 32'h0000_0000);
                chk(rd, 32'h000f_ffff);
                n[k]++;
                ov[k / 2]++;
                apb(1'b0, accs[k] + 16'h0002, 32'h0000_0000);
                chk(rd, n[k]);
                chk(32'(pulse[k / 2]), 32'(ov[k / 2][0]));
            end
        end
        $display("test accumulators done");
        for (int g = 0; g < 2; g++)
        begin
            grid_60hz <= g[0];
            // Divide by two as well: intervals stretch to 2.4 times
            if (g == 1)
                apb(1'b1, medr_pkg::IDX_METER_CTRL, 32'h0000_0017);
            for (int r = 0; r < 5; r++)
            begin
                v = xs();
                if (r == 4)
                    v = g ? 32'h0000_0258 + v % 32'h0000_03e8 : 32'h0000_0258;
                case (r)
                    0: raw <= v;
                    1: dc <= v;
                    2: avg <= v;
                    3: ap <= v;
                    default: freq <= v[15:0];
                endcase
                repeat (wt[r] * (g ? 12 : 5) / 5 + 4) @(posedge pclk);
                apb(1'b0, ri[r], 32'h0000_0000);
                v = r == 4 ? fexp(v[15:0]) : v;
                chk(rd, v);
            end
        end
        $display("test result refresh done");
        {raw, dc, avg, ap, freq} <= '0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk();
        chk(32'(pulse), 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
